/* File: dv/deq_xc_model.sv */
module deq_xc_model
  import deq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Request side
  input wire logic [deq_pkg::NUM_Q-1:0] stall,
  input wire logic [deq_pkg::NUM_Q-1:0] xreq_valid,
  input wire logic [deq_pkg::ENT_W-1:0] xreq_entry,
  output logic [deq_pkg::NUM_Q-1:0] xc_ready,
  output logic [deq_pkg::NUM_Q-1:0] xc_idle
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [ENT_W:0] got[$];
  // Ready and empty unless the bench stalls this controller
  assign xc_ready = ~stall;
  assign xc_idle = ~stall;
  // Log each request taken, tagged with the controller that took it
  always @(posedge clk) begin
    for (int q = 0; q < NUM_Q; q++) begin
      if (!sys_rst && xreq_valid[q] && xc_ready[q]) got.push_back({q[0], xreq_entry});
    end
  end
endmodule

/* File: dv/dma_event_queue_error_irq_tb_top.sv */
module dma_event_queue_error_irq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import deq_pkg::*;
  logic clk, sys_rst, awv, wv, bready, arv, rready, awr, wrd, bv, arr, rv, irq;
  logic [11:0] awa, ara;
  logic [31:0] wd, rdat, evt, d;
  logic [3:0] ws;
  logic [1:0] br, rr, r, stall, xv, xr, xi, cirq;
  logic [7:0] xe, qev;
  logic cdv;
  logic [39:0] cen;
  int err_total, checks_done, irq_cnt, cirq_cnt, cyc, seed, j, t;
  int order[18];
  deq_top u_deq_top (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .dma_evt_in(evt),
    .chain_evt_in('0), .quick_dma_evt_in(qev), .ch_code_en(cen), .code_done_valid(cdv),
    .code_done_idx('0), .xc_ready(xr), .xc_idle(xi), .xreq_valid(xv), .xreq_entry(xe),
    .error_irq_out(irq), .cmpl_irq_out(cirq));
  deq_xc_model u_deq_xc_model (.clk(clk), .sys_rst(sys_rst), .stall(stall),
    .xreq_valid(xv), .xreq_entry(xe), .xc_ready(xr), .xc_idle(xi));
  // ----------------------------------------
  // Bench tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awa <= a;
    wd <= v;
    {awv, wv, bready} <= 3'b111;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    ara <= a;
    {arv, rready} <= 2'b11;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    d = rdat;
    r = rr;
    rready <= 1'b0;
  endtask
  task automatic ev(input int ch);
    @(posedge clk);
    evt <= 32'h1 << ch;
    @(posedge clk);
    evt <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Clock, pulse counters and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (irq === 1'b1) irq_cnt++;
    if (cirq[0] === 1'b1) cirq_cnt++;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'h0c15;
    {sys_rst, awv, wv, bready, arv, rready} = 6'b100000;
    {awa, ara, wd, evt, ws, stall} = {24'h0, 64'h0, 4'hF, 2'b11};
    {qev, cdv, cen} = {9'h0, 40'hFF_FFFF_FFFF};
    for (int i = 0; i < 18; i++) order[i] = i;
    for (int i = 0; i < 18; i++) begin
      j = {$random(seed)} % 18;
      t = order[i];
      order[i] = order[j];
      order[j] = t;
    end
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFF_QUEUE_STATUS_REG);
    chk("qstat0 after reset", d, RST_WORD);
    rd(OFF_CTRL_ERR);
    chk("ctrl err after reset", d, RST_WORD);
    wr(OFF_QTHR, 32'h3);
    for (int i = 0; i < 18; i++) ev(order[i]);
    repeat (4) @(posedge clk);
    rd(OFF_QUEUE_STATUS_REG);
    chk("qstat0 full", d, 32'h0110_1000);
    rd(OFF_CTRL_ERR);
    chk("ctrl err threshold", d, 32'h1);
    chk("error pulses first", irq_cnt, 1);
    ev(20);
    ev(20);
    // Quick channel 0 twice while its queue is full
    repeat (2) begin
      @(posedge clk);
      qev <= 8'h01;
      @(posedge clk);
      qev <= 8'h00;
    end
    rd(OFF_CH_MISS);
    chk("channel missed", d, 32'h0010_0000);
    rd(OFF_QCH_MISS);
    chk("quick missed", d, 32'h0000_0001);
    chk("error pulses held", irq_cnt, 1);
    wr(OFF_ERR_RETRIG, 32'h1);
    repeat (3) @(posedge clk);
    chk("error pulses retrig", irq_cnt, 2);
    rd(OFF_ERR_RETRIG);
    chk("retrig readback", d, RST_WORD);
    while (u_deq_xc_model.got.size() < 20) begin
      @(posedge clk);
      stall <= {1'b1, 1'($random(seed))};
    end
    for (int i = 0; i < 16; i++) chk("entry order", 32'(u_deq_xc_model.got[i]), 32'({1'b0, ET_EXT, 6'(order[i])}));
    chk("quick entry", 32'(u_deq_xc_model.got[19]), 32'({1'b0, ET_AUTO, 6'(NCH)}));
    rd(OFF_QUEUE_STATUS_REG);
    chk("qstat0 drained", d & 32'h1F00, RST_WORD);
    // Twelve bypassed requests make the 32nd outstanding code
    stall <= 2'b00;
    for (int i = 0; i < 12; i++) ev(i);
    rd(OFF_CTRL_ERR);
    chk("code limit error", d, 32'h0001_0001);
    wr(OFF_CTRL_ERR_CLR, 32'hFFFF_FFFF);
    wr(OFF_CH_MISS_CLR, 32'hFFFF_FFFF);
    rd(OFF_CTRL_ERR);
    chk("ctrl err cleared", d, RST_WORD);
    rd(OFF_CH_MISS);
    chk("missed cleared", d, RST_WORD);
    rd(12'h300);
    chk("unmapped read resp", 32'(r), 32'(RESP_SLVERR));
    // Region completion pulse, retrigger and shadow clear
    wr(OFF_MASK, 32'h1);
    wr(OFF_MASK + 12'h004, 32'h2);
    rd(OFF_MASK + 12'h004);
    chk("region mask 1", d, 32'h2);
    wr(OFF_CMPL_EN, 32'h1);
    @(posedge clk);
    cdv <= 1'b1;
    @(posedge clk);
    cdv <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFF_SHD);
    chk("region pend view", d, 32'h1);
    chk("completion first", cirq_cnt, 1);
    wr(OFF_SHD + SHD_RETRIG, 32'h1);
    repeat (2) @(posedge clk);
    chk("completion retrig", cirq_cnt, 2);
    wr(OFF_SHD + SHD_CLR, 32'h1);
    rd(OFF_CMPL_PEND);
    chk("completion cleared", d, RST_WORD);
    give_verdict();
  end
endmodule

/* File: inc/deq_pkg.sv */
package deq_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NUM_Q = 2;
  localparam int DEPTH = 16;
  localparam int PW = 4;
  localparam int CW = 5;
  localparam int NCH = 32;
  localparam int NQCH = 8;
  localparam int NEV = 40;
  localparam int EVW = 6;
  localparam int ENT_W = 8;
  localparam int NREG = 2;
  localparam int RAM_AW = 5;
  localparam int AXI_AW = 12;
  localparam logic [4:0] CODE_MAX = 5'h1F;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [11:0] OFF_CH_MISS = 12'h000;
  localparam logic [11:0] OFF_CH_MISS_CLR = 12'h004;
  localparam logic [11:0] OFF_QCH_MISS = 12'h008;
  localparam logic [11:0] OFF_QCH_MISS_CLR = 12'h00C;
  localparam logic [11:0] OFF_CTRL_ERR = 12'h010;
  localparam logic [11:0] OFF_CTRL_ERR_CLR = 12'h014;
  localparam logic [11:0] OFF_ERR_RETRIG = 12'h018;
  localparam logic [11:0] OFF_EVT_SET = 12'h01C;
  localparam logic [11:0] OFF_CMPL_PEND = 12'h020;
  localparam logic [11:0] OFF_CMPL_CLR = 12'h024;
  localparam logic [11:0] OFF_CMPL_EN = 12'h028;
  localparam logic [11:0] OFF_QCH_QSEL = 12'h02C;
  localparam logic [11:0] OFF_CH_QSEL = 12'h030;
  localparam logic [11:0] OFF_QTHR = 12'h034;
  localparam logic [11:0] OFF_QUEUE_STATUS_REG = 12'h038;
  localparam logic [11:0] OFF_MASK = 12'h040;
  localparam logic [11:0] OFF_SHD = 12'h080;
  localparam logic [11:0] SHD_STRIDE = 12'h010;
  localparam logic [11:0] SHD_PEND = 12'h000;
  localparam logic [11:0] SHD_CLR = 12'h004;
  localparam logic [11:0] SHD_RETRIG = 12'h008;
  localparam logic [11:0] OFF_QENT = 12'h400;
  localparam logic [11:0] QENT_STRIDE = 12'h040;
  // ----------------------------------------
  // Fields and codes
  // ----------------------------------------
  localparam int QS_HEAD = 0;
  localparam int QS_CNT = 8;
  localparam int QS_PEAK = 16;
  localparam int QS_THRX = 24;
  localparam int THR_W = 4;
  localparam int ERR_CODE_BIT = 16;
  localparam int RETRIG_BIT = 0;
  localparam logic [1:0] ET_MANUAL = 2'h0;
  localparam logic [1:0] ET_EXT = 2'h1;
  localparam logic [1:0] ET_CHAIN = 2'h2;
  localparam logic [1:0] ET_AUTO = 2'h3;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_SEND = 3'b100
  } deq_state_e;
endpackage

/* File: inc/deq_ram_if.sv */
interface deq_ram_if;
  import deq_pkg::*;
  logic wr_en;
  logic [RAM_AW-1:0] wr_addr;
  logic [ENT_W-1:0] wr_data;
  logic [RAM_AW-1:0] rd_addr_a;
  logic [ENT_W-1:0] rd_data_a;
  logic [RAM_AW-1:0] rd_addr_b;
  logic [ENT_W-1:0] rd_data_b;
  modport ctrl (output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
                input rd_data_a, rd_data_b);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b,
               output rd_data_a, rd_data_b);
endinterface

/* File: logic/deq_queue_ram.sv */
module deq_queue_ram
  import deq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Storage port
  deq_ram_if.mem ram
);
  logic [ENT_W-1:0] mem_reg [NUM_Q*DEPTH];

  // Entry storage, kept after dequeue for inspection
  always_ff @(posedge clk) begin
    if (ram.wr_en) begin
      mem_reg[ram.wr_addr] <= ram.wr_data;
    end
  end

  // Two registered read ports
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ram.rd_data_a <= '0;
      ram.rd_data_b <= '0;
    end else begin
      ram.rd_data_a <= mem_reg[ram.rd_addr_a];
      ram.rd_data_b <= mem_reg[ram.rd_addr_b];
    end
  end
endmodule

/* File: logic/deq_top.sv */
// What this block does
// - Region retrigger write of one pulses region completion irq if enabled bits pending.
// - Region retrigger registers ignore the region access mask.
// - Error retrigger write of one pulses error irq if any error bit pending.
// - One error irq output fed by four error categories.
// - Missed event on any of 32 channels latches in channel missed register.
// - Missed quick channel event latches in quick channel missed register.
// - Queue threshold exceeded latches a per-queue bit in controller error register.
// - More than 31 outstanding completion-code requests sets the code error bit.
// - Error irq has no enable mask.
// - Error irq pulses only on transition from no error bits to some.
// - New error bits while others remain set give no further pulse.
// - Queues hold 16 entries; events not enqueued stay pending.
// - Queue n submits only to transfer controller n.
// - Winning event is appended at its queue tail; queues are first-in first-out.
// - Head dequeued only when its controller is ready, then submitted to it.
// - Lowest-numbered ready queue is dequeued first.
// - Queue entries are read-only and hold event type and number.
// - Each channel and quick channel has its own queue selection.
// - Event bypasses an empty queue with an empty controller, unrecorded.
// - Circular queues expose head pointer and valid count; old entries kept.
// - Threshold 0 to 15 per queue; peak usage tracks largest count.
// - Exceeding threshold sets controller error bit and queue status flag.
// - Region completion irq is OR of pending and enable and access mask.
// - Region completion irq pulses only on none-to-some transition.
// - Writing one to completion clear clears that pending bit.
module deq_top
  import deq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // AXI4-Lite slave
  input wire logic [deq_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [deq_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event sources
  input wire logic [deq_pkg::NCH-1:0] dma_evt_in,
  input wire logic [deq_pkg::NCH-1:0] chain_evt_in,
  input wire logic [deq_pkg::NQCH-1:0] quick_dma_evt_in,
  // Completion codes
  input wire logic [deq_pkg::NEV-1:0] ch_code_en,
  input wire logic code_done_valid,
  input wire logic [4:0] code_done_idx,
  // Transfer controllers
  input wire logic [deq_pkg::NUM_Q-1:0] xc_ready,
  input wire logic [deq_pkg::NUM_Q-1:0] xc_idle,
  output logic [deq_pkg::NUM_Q-1:0] xreq_valid,
  output logic [deq_pkg::ENT_W-1:0] xreq_entry,
  // Interrupts
  output logic error_irq_out,
  output logic [deq_pkg::NREG-1:0] cmpl_irq_out
);
  import deq_pkg::*;

  // Lowest set bit index
  function automatic logic [EVW-1:0] first_set(input logic [NEV-1:0] v);
    logic [EVW-1:0] r;
    r = '0;
    for (int i = NEV - 1; i >= 0; i--) begin
      if (v[i]) r = EVW'(i);
    end
    return r;
  endfunction

  // Byte strobe to bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  deq_ram_if rif ();
  deq_queue_ram u_ram (.clk(clk), .sys_rst(sys_rst), .ram(rif.mem));

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  logic aw_held_reg, w_held_reg, ar_stage_reg;
  logic [AXI_AW-1:0] aw_addr_reg, ar_addr_reg;
  logic [31:0] w_data_reg, w_mask_reg, rdata_next;
  logic rerr_next;
  wire wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire [11:0] wa = aw_addr_reg;
  wire [31:0] wbits = w_data_reg & w_mask_reg;
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready = ~w_held_reg;
  assign s_axi_arready = ~s_axi_rvalid & ~ar_stage_reg;

  // Address and data taken in either order
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_data_reg <= RST_WORD;
      w_mask_reg <= RST_WORD;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) aw_addr_reg <= s_axi_awaddr;
      if (s_axi_wvalid & s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_mask_reg <= lane_mask(s_axi_wstrb);
      end
      aw_held_reg <= wr_fire ? 1'b0 : (aw_held_reg | s_axi_awvalid);
      w_held_reg <= wr_fire ? 1'b0 : (w_held_reg | s_axi_wvalid);
      s_axi_bvalid <= wr_fire | (s_axi_bvalid & ~s_axi_bready);
    end
  end

  // Write decode
  wire wr_ch_clr = wr_fire & (wa == OFF_CH_MISS_CLR);
  wire wr_qch_clr = wr_fire & (wa == OFF_QCH_MISS_CLR);
  wire wr_err_clr = wr_fire & (wa == OFF_CTRL_ERR_CLR);
  wire err_retrig = wr_fire & (wa == OFF_ERR_RETRIG) & wbits[RETRIG_BIT];
  wire wr_evt_set = wr_fire & (wa == OFF_EVT_SET);
  wire wr_cmpl_clr = wr_fire & (wa == OFF_CMPL_CLR);
  wire wr_cmpl_en = wr_fire & (wa == OFF_CMPL_EN);
  wire wr_qch_qsel = wr_fire & (wa == OFF_QCH_QSEL);
  wire wr_ch_qsel = wr_fire & (wa == OFF_CH_QSEL);
  wire wr_qthr = wr_fire & (wa == OFF_QTHR);
  logic [NREG-1:0] wr_mask, wr_shd_clr, cmpl_retrig, hit_region;
  logic wr_known;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [NCH-1:0] ch_miss_reg, ch_qsel_reg, cmpl_pend_reg, cmpl_en_reg;
  logic [NQCH-1:0] qch_miss_reg, qch_qsel_reg;
  logic [31:0] ctrl_err_reg, cmpl_clr_bits;
  logic [NEV-1:0] evt_pend_reg;
  logic [1:0] evt_type_reg [NEV];
  logic [NCH-1:0] mask_reg [NREG];
  logic [PW-1:0] head_reg [NUM_Q];
  logic [CW-1:0] cnt_reg [NUM_Q], cnt_next [NUM_Q], peak_reg [NUM_Q];
  logic [THR_W-1:0] thr_reg [NUM_Q];
  logic [NUM_Q-1:0] thrx_reg, q_full, thr_hit, deq_cand;
  logic [NREG-1:0] act_q_reg, act;
  logic err_q_reg;
  logic [4:0] code_out_reg;
  deq_state_e state_reg;
  logic [0:0] sel_q_reg;

  // Region decode and completion region logic
  always_comb begin
    cmpl_clr_bits = wr_cmpl_clr ? wbits : '0;
    for (int r = 0; r < NREG; r++) begin
      hit_region[r] = (wa == OFF_MASK + 12'(4 * r)) |
                      (wa == OFF_SHD + SHD_STRIDE * 12'(r) + SHD_CLR) |
                      (wa == OFF_SHD + SHD_STRIDE * 12'(r) + SHD_RETRIG);
      wr_mask[r] = wr_fire & (wa == OFF_MASK + 12'(4 * r));
      wr_shd_clr[r] = wr_fire & (wa == OFF_SHD + SHD_STRIDE * 12'(r) + SHD_CLR);
      // Retrigger is not gated by the access mask
      cmpl_retrig[r] = wr_fire & wbits[RETRIG_BIT] &
                       (wa == OFF_SHD + SHD_STRIDE * 12'(r) + SHD_RETRIG);
      if (wr_shd_clr[r]) cmpl_clr_bits = cmpl_clr_bits | (wbits & mask_reg[r]);
      act[r] = |(cmpl_pend_reg & cmpl_en_reg & mask_reg[r]);
    end
    wr_known = (wa <= OFF_QUEUE_STATUS_REG) | (|hit_region);
  end

  // ----------------------------------------
  // Event prioritisation and queues
  // ----------------------------------------
  wire [NEV-1:0] all_qsel = {qch_qsel_reg, ch_qsel_reg};
  wire [NCH-1:0] man_set = wr_evt_set ? wbits : '0;
  wire [NCH-1:0] dma_src = dma_evt_in | chain_evt_in | man_set;
  wire [NEV-1:0] new_src = {quick_dma_evt_in, dma_src};
  wire [NEV-1:0] man_all = {{NQCH{1'b0}}, man_set};
  wire [NEV-1:0] chain_all = {{NQCH{1'b0}}, chain_evt_in};
  wire [NCH-1:0] miss_dma = dma_src & evt_pend_reg[NCH-1:0];
  wire [NQCH-1:0] miss_quick_dma = quick_dma_evt_in & evt_pend_reg[NEV-1:NCH];
  logic [NEV-1:0] elig;
  always_comb begin
    for (int i = 0; i < NEV; i++) elig[i] = evt_pend_reg[i] & ~q_full[all_qsel[i]];
  end
  wire win_any = |elig;
  wire [EVW-1:0] win_idx = first_set(elig);
  wire [0:0] win_q = all_qsel[win_idx];
  wire [ENT_W-1:0] win_entry = {evt_type_reg[win_idx], win_idx};
  wire deq_any = (state_reg == ST_IDLE) & (|deq_cand);
  wire [EVW-1:0] deq_full = first_set({{(NEV - NUM_Q){1'b0}}, deq_cand});
  wire [0:0] deq_q = deq_full[0];
  wire byp = (state_reg == ST_IDLE) & ~deq_any & win_any & (cnt_reg[win_q] == '0) &
             xc_idle[win_q] & xc_ready[win_q];
  wire enq = win_any & ~byp;
  wire sub_fire = (state_reg == ST_SEND) & xc_ready[sel_q_reg];
  wire code_req = sub_fire & ch_code_en[xreq_entry[EVW-1:0]];
  wire code_err = code_req & (code_out_reg == CODE_MAX);
  wire err_any = (|ch_miss_reg) | (|qch_miss_reg) | (|ctrl_err_reg);
  wire [PW-1:0] tail = head_reg[win_q] + cnt_reg[win_q][PW-1:0];

  // Queue storage ports
  assign rif.wr_en = enq;
  assign rif.wr_addr = {win_q, tail};
  assign rif.wr_data = win_entry;
  assign rif.rd_addr_a = {deq_q, head_reg[deq_q]};
  assign rif.rd_addr_b = {s_axi_araddr[6], s_axi_araddr[5:2]};

  // Per-queue counters and status
  for (genvar q = 0; q < NUM_Q; q++) begin : g_q
    wire enq_q = enq & (win_q == 1'(q));
    wire deq_q_w = deq_any & (deq_q == 1'(q));
    assign deq_cand[q] = (cnt_reg[q] != '0) & xc_ready[q];
    assign q_full[q] = cnt_reg[q] == CW'(DEPTH);
    assign cnt_next[q] = cnt_reg[q] + CW'(enq_q) - CW'(deq_q_w);
    assign thr_hit[q] = enq_q & (cnt_next[q] > CW'(thr_reg[q]));
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        head_reg[q] <= '0;
        cnt_reg[q] <= '0;
        peak_reg[q] <= '0;
        thrx_reg[q] <= 1'b0;
        thr_reg[q] <= '0;
      end else begin
        head_reg[q] <= head_reg[q] + PW'(deq_q_w);
        cnt_reg[q] <= cnt_next[q];
        if (cnt_next[q] > peak_reg[q]) peak_reg[q] <= cnt_next[q];
        if (wr_qthr) thr_reg[q] <= wbits[8 * q +: THR_W];
        thrx_reg[q] <= thr_hit[q] | (thrx_reg[q] & ~(wr_err_clr & wbits[q]));
      end
    end
  end

  // Pending events and their types
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_pend_reg <= '0;
      for (int i = 0; i < NEV; i++) evt_type_reg[i] <= ET_MANUAL;
    end else begin
      for (int i = 0; i < NEV; i++) begin
        evt_pend_reg[i] <= new_src[i] | (evt_pend_reg[i] & ~(win_any &
                           (win_idx == EVW'(i))));
        if (new_src[i] & ~evt_pend_reg[i]) begin
          if (i >= NCH) evt_type_reg[i] <= ET_AUTO;
          else if (man_all[i]) evt_type_reg[i] <= ET_MANUAL;
          else if (chain_all[i]) evt_type_reg[i] <= ET_CHAIN;
          else evt_type_reg[i] <= ET_EXT;
        end
      end
    end
  end

  // Dequeue and submission sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      sel_q_reg <= '0;
      xreq_entry <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (deq_any) begin
            sel_q_reg <= deq_q;
            state_reg <= ST_FETCH;
          end else if (byp) begin
            sel_q_reg <= win_q;
            xreq_entry <= win_entry;
            state_reg <= ST_SEND;
          end
        end
        ST_FETCH: begin
          xreq_entry <= rif.rd_data_a;
          state_reg <= ST_SEND;
        end
        ST_SEND: begin
          if (sub_fire) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // Queue n only drives controller n
  assign xreq_valid = (state_reg == ST_SEND) ? (NUM_Q'(1) << sel_q_reg) : '0;

  // ----------------------------------------
  // Errors, completion and interrupts
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ch_miss_reg <= '0;
      qch_miss_reg <= '0;
      ctrl_err_reg <= RST_WORD;
      code_out_reg <= '0;
      err_q_reg <= 1'b0;
      error_irq_out <= 1'b0;
    end else begin
      ch_miss_reg <= miss_dma | (ch_miss_reg & ~(wr_ch_clr ? wbits : '0));
      qch_miss_reg <= miss_quick_dma | (qch_miss_reg & ~(wr_qch_clr ? wbits[NQCH-1:0] : '0));
      ctrl_err_reg[NUM_Q-1:0] <= thr_hit |
        (ctrl_err_reg[NUM_Q-1:0] & ~(wr_err_clr ? wbits[NUM_Q-1:0] : '0));
      ctrl_err_reg[ERR_CODE_BIT] <= code_err |
        (ctrl_err_reg[ERR_CODE_BIT] & ~(wr_err_clr & wbits[ERR_CODE_BIT]));
      code_out_reg <= code_out_reg + 5'(code_req & ~code_err) -
                      5'(code_done_valid & (code_out_reg != '0));
      err_q_reg <= err_any;
      // No enable: any error bit may raise the line
      error_irq_out <= (err_any & ~err_q_reg) | (err_retrig & err_any);
    end
  end

  // Completion pending, enables and region masks
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpl_pend_reg <= '0;
      cmpl_en_reg <= '0;
      ch_qsel_reg <= '0;
      qch_qsel_reg <= '0;
      act_q_reg <= '0;
      cmpl_irq_out <= '0;
      for (int r = 0; r < NREG; r++) mask_reg[r] <= '0;
    end else begin
      cmpl_pend_reg <= (cmpl_pend_reg & ~cmpl_clr_bits) |
                       (code_done_valid ? (NCH'(1) << code_done_idx) : '0);
      if (wr_cmpl_en) cmpl_en_reg <= (cmpl_en_reg & ~w_mask_reg) | wbits;
      if (wr_ch_qsel) ch_qsel_reg <= (ch_qsel_reg & ~w_mask_reg) | wbits;
      if (wr_qch_qsel) qch_qsel_reg <= wbits[NQCH-1:0];
      act_q_reg <= act;
      cmpl_irq_out <= (act & ~act_q_reg) | (cmpl_retrig & act);
      for (int r = 0; r < NREG; r++) begin
        if (wr_mask[r]) mask_reg[r] <= (mask_reg[r] & ~w_mask_reg) | wbits;
      end
    end
  end

  // Read data select
  wire [11:0] ra = ar_addr_reg;
  wire [0:0] rq = ra[2];
  always_comb begin
    rdata_next = RST_WORD;
    rerr_next = 1'b0;
    if (ra >= OFF_QENT && ra < OFF_QENT + QENT_STRIDE * 12'(NUM_Q)) begin
      rdata_next = {24'h0, rif.rd_data_b};
    end else if (ra == OFF_QUEUE_STATUS_REG || ra == OFF_QUEUE_STATUS_REG + 12'h004) begin
      rdata_next[QS_HEAD +: PW] = head_reg[ra[2]];
      rdata_next[QS_CNT +: CW] = cnt_reg[ra[2]];
      rdata_next[QS_PEAK +: CW] = peak_reg[ra[2]];
      rdata_next[QS_THRX] = thrx_reg[ra[2]];
    end else if (ra[11:4] == OFF_MASK[11:4] && ra[3:2] < 2'(NREG)) begin
      rdata_next = mask_reg[rq];
    end else if (ra[11:5] == OFF_SHD[11:5]) begin
      rdata_next = (ra[3:0] == SHD_PEND[3:0]) ? (cmpl_pend_reg & mask_reg[ra[4]]) : '0;
    end else begin
      unique case (ra)
        OFF_CH_MISS: rdata_next = ch_miss_reg;
        OFF_QCH_MISS: rdata_next = {24'h0, qch_miss_reg};
        OFF_CTRL_ERR: rdata_next = ctrl_err_reg;
        OFF_CMPL_PEND: rdata_next = cmpl_pend_reg;
        OFF_CMPL_EN: rdata_next = cmpl_en_reg;
        OFF_QCH_QSEL: rdata_next = {24'h0, qch_qsel_reg};
        OFF_CH_QSEL: rdata_next = ch_qsel_reg;
        OFF_QTHR: rdata_next = {20'h0, thr_reg[1], 4'h0, thr_reg[0]};
        OFF_CH_MISS_CLR, OFF_QCH_MISS_CLR, OFF_CTRL_ERR_CLR, OFF_ERR_RETRIG,
        OFF_EVT_SET, OFF_CMPL_CLR: rdata_next = RST_WORD;
        default: rerr_next = 1'b1;
      endcase
    end
  end

  // Read channel, one stage behind the address
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ar_stage_reg <= 1'b0;
      ar_addr_reg <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_WORD;
      s_axi_rresp <= RESP_OK;
      s_axi_bresp <= RESP_OK;
    end else begin
      if (ar_fire) ar_addr_reg <= s_axi_araddr;
      ar_stage_reg <= ar_fire;
      if (ar_stage_reg) begin
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= rerr_next ? RESP_SLVERR : RESP_OK;
      end
      s_axi_rvalid <= ar_stage_reg | (s_axi_rvalid & ~s_axi_rready);
      if (wr_fire) s_axi_bresp <= wr_known ? RESP_OK : RESP_SLVERR;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_deq_start;
    deq_any && deq_cand[0];
  endsequence
  sequence s_deq_path;
    (state_reg == ST_FETCH && sel_q_reg == 1'b0) ##1 (state_reg == ST_SEND);
  endsequence
  a_err_edge_pulse: assert property (err_any && !err_q_reg |=> error_irq_out)
    else $error("error irq missing on first error");
  a_err_no_repeat: assert property (err_q_reg && err_any && !err_retrig |=> !error_irq_out)
    else $error("extra error irq pulse");
  a_err_retrig: assert property (err_retrig && err_any |=> error_irq_out)
    else $error("error retrigger ignored");
  a_cmpl_retrig: assert property (cmpl_retrig[0] && act[0] |=> cmpl_irq_out[0])
    else $error("completion retrigger ignored");
  a_queue_cap: assert property (cnt_reg[0] <= CW'(DEPTH) && cnt_reg[1] <= CW'(DEPTH))
    else $error("queue count above depth");
  a_bypass_skip: assert property (byp |=> state_reg == ST_SEND && cnt_reg[sel_q_reg] == '0)
    else $error("bypass recorded in queue");
  a_deq_order: assert property (s_deq_start |=> s_deq_path)
    else $error("queue 0 not served first");
  a_code_limit: assert property (code_req && code_out_reg == CODE_MAX
                                 |=> ctrl_err_reg[ERR_CODE_BIT])
    else $error("code limit error not flagged");
  a_thr_flag: assert property (thr_hit[0] |=> thrx_reg[0] && ctrl_err_reg[0])
    else $error("threshold flag not set");
  a_miss_latch: assert property ((|miss_dma) |=>
                                 (ch_miss_reg & $past(miss_dma)) == $past(miss_dma))
    else $error("missed event lost");
endmodule
